// ### verilog/dpc_defines.svh
/*
 * constants for the pin-level command interface of a ddr2 memory device:
 * command codes, mode register selects, field positions, burst shape.
 * assumes nothing; definitions only.
 */
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH

// ==========================================================================
// widths
`define DPC_DQ_W        8
`define DPC_BA_W        3
`define DPC_ADDR_W      16
`define DPC_COL_W       4
`define DPC_FIFO_DEPTH  8

// ==========================================================================
// command codes {cs_n, ras_n, cas_n, we_n}
`define DPC_CMD_MRS     4'h0
`define DPC_CMD_REF     4'h1
`define DPC_CMD_PRE     4'h2
`define DPC_CMD_ACT     4'h3
`define DPC_CMD_WR      4'h4
`define DPC_CMD_RD      4'h5
`define DPC_CMD_NOP     4'h7

// ==========================================================================
// mode register select on the bank inputs
`define DPC_MR_BASE     2'h0
`define DPC_MR_EXT1     2'h1

// ==========================================================================
// field positions on the address inputs
`define DPC_A_AP        10
`define DPC_E1_RTT0     2
`define DPC_E1_RTT1     6
`define DPC_E1_DQSN_DIS 10
`define DPC_E1_RDQS_EN  11

// ==========================================================================
// reset values and burst
`define DPC_MR_RST      16'h0000
`define DPC_BURST       3'h4

`endif

// ### verilog/dpc_pkg.sv
/*
 * types for the ddr2 pin command interface.
 * assumes dpc_defines.svh is on the include path.
 */
`include "dpc_defines.svh"

package dpc_pkg;

    typedef struct packed {
        logic                     ck_t;
        logic                     ck_c;
        logic                     cke;
        logic                     cs_n;
        logic                     ras_n;
        logic                     cas_n;
        logic                     we_n;
        logic                     odt;
        logic [`DPC_BA_W-1:0]     ba;
        logic [`DPC_ADDR_W-1:0]   addr;
        logic [`DPC_DQ_W-1:0]     dq;
        logic                     dm;
        logic                     dqs;
    } dpc_pins_t;

    typedef struct packed {
        logic dq;
        logic dqs;
        logic dm;
    } dpc_term_t;

    typedef enum logic [1:0] {
        PS_ACTIVE,
        PS_PDN_PRE,
        PS_PDN_ACT,
        PS_SREF
    } dpc_pwr_t;

endpackage

// ### verilog/dpc_pin_cmd.sv
/*
 * ddr2 device-side pin command logic: command sampling, power-down and
 * self-refresh gating, termination, write masking, bank and mode register
 * selection, precharge scope, double-rate read drive through a fifo.
 * assumes one 40 MHz clk oversampling the controller's ck pair; all pins
 * arrive asynchronous and are double registered here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.svh"

// ==========================================================================
// fifo
module dpc_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // dpc_fifo

// ==========================================================================
// top
// Overview of operation
// - sample address and control on ck rising crossing
// - read data driven on both ck crossings
// - cke high runs buffers, low stops them
// - cke low: precharge/self-refresh or active power-down
// - cke entry and power-down exit events taken on ck edges
// - self-refresh exit on cke rise, no clock
// - power-down gates all inputs but ck, cke and the dq, dm, dqs beats of a write burst in progress
// - self-refresh gates all inputs but cke and the dq, dm, dqs beats of a write burst in progress
// - chip select high masks the command
// - command from cs, ras, cas, we together
// - odt high terminates dq, strobe and mask
// - odt ignored when extended register disables it
// - mask sampled on both strobe edges, blocks beats
// - x8 mask pin doubles as read strobe
// - bank inputs pick bank; top bit unused
// - bank value selects mode register on set
// - row on activate, column and ap otherwise
// - precharge one bank, or all when a10 high
// - mode register set loads opcode from address
// - read strobe edge-aligned; write strobe centred
// - one extended bit disables complementary strobes
module dpc_pin_cmd
    import dpc_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // pins from the controller
    input  wire dpc_pins_t              pins,
    // data pin drivers
    output logic [`DPC_DQ_W-1:0]        dq_o,
    output logic                        dq_oe_n,
    output logic                        dqs_o,
    output logic                        dqs_oe_n,
    output logic                        dqs_c_o,
    output logic                        dqs_c_oe_n,
    output logic                        rdqs_o,
    output logic                        rdqs_oe_n,
    // termination and power state
    output dpc_term_t                   term,
    output logic                        buf_en,
    output dpc_pwr_t                    pwr_state,
    output logic [3:0]                  bank_open
);
    // ======================================================================
    // reset release and pin synchronisers
    logic       rst_s1_r;
    logic       rst_n;
    dpc_pins_t  s1_r;
    dpc_pins_t  s2_r;
    dpc_pins_t  s3_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // s3 only serves edge detection; nothing reads s1 but s2
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // ======================================================================
    // edges and command decode
    logic       ck_rise;
    logic       ck_any;
    logic       dqs_edge;
    logic [3:0] cmd;
    logic       cmd_ok;
    logic [1:0] bank;
    logic       cke_prev_r;
    dpc_pwr_t   pwr_r;
    logic       all_idle;

    assign ck_rise  = s2_r.ck_t & ~s3_r.ck_t & ~s2_r.ck_c & s3_r.ck_c;
    assign ck_any   = s2_r.ck_t ^ s3_r.ck_t;
    assign dqs_edge = s2_r.dqs ^ s3_r.dqs;
    assign cmd      = {s2_r.cs_n, s2_r.ras_n, s2_r.cas_n, s2_r.we_n};
    assign bank     = s2_r.ba[1:0];
    assign all_idle = (bank_open == 4'h0);
    // commands only while awake and cke held high at the edge
    assign cmd_ok   = ck_rise & (pwr_r == PS_ACTIVE) & cke_prev_r
                      & s2_r.cke & ~s2_r.cs_n;

    // ======================================================================
    // power state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_r      <= PS_ACTIVE;
            cke_prev_r <= 1'b1;
        end else begin
            case (pwr_r)
                PS_ACTIVE: begin
                    if (ck_rise) begin
                        cke_prev_r <= s2_r.cke;
                        if (cke_prev_r & ~s2_r.cke) begin
                            if (~s2_r.cs_n && cmd == `DPC_CMD_REF
                                && all_idle) begin
                                pwr_r <= PS_SREF;
                            end else if (all_idle) begin
                                pwr_r <= PS_PDN_PRE;
                            end else begin
                                pwr_r <= PS_PDN_ACT;
                            end
                        end
                    end
                end
                PS_PDN_PRE, PS_PDN_ACT: begin
                    // only ck and cke are looked at here
                    if (ck_rise && s2_r.cke) begin
                        pwr_r      <= PS_ACTIVE;
                        cke_prev_r <= 1'b1;
                    end
                end
                PS_SREF: begin
                    // ck may be stopped; cke level alone wakes us
                    if (s2_r.cke) begin
                        pwr_r      <= PS_ACTIVE;
                        cke_prev_r <= 1'b1;
                    end
                end
                default: begin
                    pwr_r <= PS_ACTIVE;
                end
            endcase
        end
    end

    assign pwr_state = pwr_r;
    assign buf_en    = (pwr_r == PS_ACTIVE);

    // ======================================================================
    // mode registers
    logic [`DPC_ADDR_W-1:0] mr0_r;
    logic [`DPC_ADDR_W-1:0] emr1_r;
    logic                   odt_r;
    logic                   rtt_on;
    logic                   rdqs_en;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mr0_r  <= `DPC_MR_RST;
            emr1_r <= `DPC_MR_RST;
        end else if (cmd_ok && cmd == `DPC_CMD_MRS) begin
            if (bank == `DPC_MR_BASE) begin
                mr0_r <= s2_r.addr;
            end else if (bank == `DPC_MR_EXT1) begin
                emr1_r <= s2_r.addr;
            end
        end
    end

    assign rtt_on  = emr1_r[`DPC_E1_RTT0] | emr1_r[`DPC_E1_RTT1];
    assign rdqs_en = emr1_r[`DPC_E1_RDQS_EN];

    // odt is registered on ck like any control input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            odt_r <= 1'b0;
        end else if (ck_rise && pwr_r == PS_ACTIVE) begin
            odt_r <= s2_r.odt & rtt_on;
        end
    end

    // mask pin stays terminated in read strobe mode as well
    assign term = '{dq: odt_r, dqs: odt_r, dm: odt_r};

    // ======================================================================
    // banks, rows and storage
    logic [`DPC_ADDR_W-1:0] row_r [4];
    logic [3:0]             open_r;
    logic [`DPC_DQ_W-1:0]   mem_r [64];
    logic [1:0]             wr_bank_r;
    logic [`DPC_COL_W-1:0]  wr_col_r;
    logic [2:0]             wr_left_r;
    logic                   wr_ap_r;
    logic [1:0]             rd_bank_r;
    logic [`DPC_COL_W-1:0]  rd_col_r;
    logic [2:0]             rd_left_r;
    logic                   rd_ap_r;
    logic                   f_in_ready;
    logic                   f_in_valid;
    logic                   wr_beat;
    logic                   ap_close;

    assign bank_open  = open_r;
    assign f_in_valid = (rd_left_r != 3'h0);
    assign wr_beat    = dqs_edge & (wr_left_r != 3'h0);
    assign ap_close   = (wr_beat & (wr_left_r == 3'h1) & wr_ap_r)
                        | (f_in_valid & f_in_ready & (rd_left_r == 3'h1)
                           & rd_ap_r);

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_bank
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    open_r[gb] <= 1'b0;
                    row_r[gb]  <= '0;
                end else if (cmd_ok && cmd == `DPC_CMD_ACT
                             && bank == 2'(gb)) begin
                    open_r[gb] <= 1'b1;
                    row_r[gb]  <= s2_r.addr;
                end else if (cmd_ok && cmd == `DPC_CMD_PRE
                             && (s2_r.addr[`DPC_A_AP]
                                 || bank == 2'(gb))) begin
                    open_r[gb] <= 1'b0;
                end else if (ap_close && ((wr_left_r == 3'h1
                             && wr_bank_r == 2'(gb))
                             || (rd_left_r == 3'h1
                             && rd_bank_r == 2'(gb)))) begin
                    open_r[gb] <= 1'b0;
                end
            end
        end
    endgenerate

    // write burst: beats taken on each strobe edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_left_r <= 3'h0;
            wr_bank_r <= 2'h0;
            wr_col_r  <= '0;
            wr_ap_r   <= 1'b0;
        end else if (cmd_ok && cmd == `DPC_CMD_WR) begin
            wr_left_r <= `DPC_BURST;
            wr_bank_r <= bank;
            wr_col_r  <= s2_r.addr[`DPC_COL_W-1:0];
            wr_ap_r   <= s2_r.addr[`DPC_A_AP];
        end else if (wr_beat) begin
            wr_left_r <= wr_left_r - 3'h1;
            wr_col_r  <= wr_col_r + 1'b1;
        end
    end

    // masked beats leave the array untouched
    always_ff @(posedge clk) begin
        if (wr_beat && !(s2_r.dm && !rdqs_en)) begin
            mem_r[{wr_bank_r, wr_col_r}] <= s2_r.dq;
        end
    end

    // read burst: beats pushed into the fifo, stalled when full
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_left_r <= 3'h0;
            rd_bank_r <= 2'h0;
            rd_col_r  <= '0;
            rd_ap_r   <= 1'b0;
        end else if (cmd_ok && cmd == `DPC_CMD_RD) begin
            rd_left_r <= `DPC_BURST;
            rd_bank_r <= bank;
            rd_col_r  <= s2_r.addr[`DPC_COL_W-1:0];
            rd_ap_r   <= s2_r.addr[`DPC_A_AP];
        end else if (f_in_valid && f_in_ready) begin
            rd_left_r <= rd_left_r - 3'h1;
            rd_col_r  <= rd_col_r + 1'b1;
        end
    end

    // ======================================================================
    // read drive on both ck crossings
    logic                 f_out_valid;
    logic                 f_pop;
    logic [`DPC_DQ_W-1:0] f_out_data;

    assign f_pop = ck_any & buf_en;

    dpc_fifo #(
        .W (`DPC_DQ_W),
        .D (`DPC_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (mem_r[{rd_bank_r, rd_col_r}]),
        .out_valid (f_out_valid),
        .out_ready (f_pop),
        .out_data  (f_out_data)
    );

    // strobe follows ck so each beat edge sits on a strobe edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_o       <= '0;
            dq_oe_n    <= 1'b1;
            dqs_o      <= 1'b0;
            dqs_c_o    <= 1'b1;
            dqs_oe_n   <= 1'b1;
            dqs_c_oe_n <= 1'b1;
            rdqs_o     <= 1'b0;
            rdqs_oe_n  <= 1'b1;
        end else if (!buf_en) begin
            dq_oe_n    <= 1'b1;
            dqs_oe_n   <= 1'b1;
            dqs_c_oe_n <= 1'b1;
            rdqs_oe_n  <= 1'b1;
        end else if (f_pop) begin
            dq_o       <= f_out_data;
            dq_oe_n    <= ~f_out_valid;
            dqs_o      <= s2_r.ck_t;
            dqs_c_o    <= ~s2_r.ck_t;
            dqs_oe_n   <= ~f_out_valid;
            dqs_c_oe_n <= ~f_out_valid | emr1_r[`DPC_E1_DQSN_DIS];
            rdqs_o     <= s2_r.ck_t;
            rdqs_oe_n  <= ~(f_out_valid & rdqs_en);
        end
    end

endmodule // dpc_pin_cmd

`default_nettype wire

// ### sim/dpc_ctrl_model.sv
/*
 * behavioural memory controller facing dpc_pin_cmd: ck pair, commands,
 * odt, write beats. assumes clk from the bench; changes at clk falls.
 */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// controller model
module dpc_ctrl_model
    import dpc_pkg::*;
#(
    parameter int H = 6
) (
    input  wire logic      clk,
    output var dpc_pins_t  pins
);
    initial begin
        pins = '0;
        pins.ck_c = 1'b1;
        pins.cke = 1'b1;
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = 4'hf;
    end

    task automatic w(int n);
        repeat (n) @(negedge clk);
    endtask

    // both legs flip together, half period of H clk
    task automatic tick();
        pins.ck_t = ~pins.ck_t;
        pins.ck_c = ~pins.ck_t;
        w(H);
    endtask

    task automatic cmd(logic [3:0] c, logic [2:0] b, logic [15:0] a,
                       logic k);
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = c;
        pins.ba = b;
        pins.addr = a;
        pins.cke = k;
        w(H);
        tick();
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = 4'hf;
        pins.addr = ~a;
        // no beat here: drive dq with a moving pattern, not the last beat
        pins.dq = ~pins.dq;
        tick();
    endtask

    task automatic set_odt(logic v);
        pins.odt = v;
    endtask

    // strobe edge lands mid-beat; strobe parked between bursts
    task automatic beat(logic [7:0] d, logic m);
        pins.dq = d;
        pins.dm = m;
        w(3);
        pins.dqs = ~pins.dqs;
        w(3);
    endtask

    // self-refresh exit with the ck pair stopped
    task automatic wake();
        pins.cke = 1'b1;
        w(H);
    endtask
endmodule // dpc_ctrl_model

`default_nettype wire

// ### sim/dpc_pin_cmd_props.sv
/*
 * port checker for dpc_pin_cmd: power gating, termination, strobes.
 * assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.svh"

// ==========================================================================
// checker
module dpc_pin_cmd_props
    import dpc_pkg::*;
(
    input wire logic       clk,
    input wire logic       nrst,
    input wire dpc_pins_t  pins,
    input wire logic       dq_oe_n,
    input wire logic       dqs_o,
    input wire logic       dqs_oe_n,
    input wire logic       dqs_c_o,
    input wire logic       dqs_c_oe_n,
    input wire logic       rdqs_oe_n,
    input wire dpc_term_t  term,
    input wire logic       buf_en,
    input wire dpc_pwr_t   pwr_state,
    input wire logic [3:0] bank_open
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_asleep;
        pwr_state != PS_ACTIVE ##1 pwr_state != PS_ACTIVE;
    endsequence
    sequence s_wake;
        pwr_state == PS_SREF && $rose(pins.cke) ##1 pins.cke [*3];
    endsequence

    property p_buf_gate;
        buf_en == (pwr_state == PS_ACTIVE);
    endproperty
    property p_drv_off;
        !buf_en |-> dq_oe_n && dqs_oe_n && rdqs_oe_n;
    endproperty
    property p_pdn_act;
        pwr_state == PS_PDN_ACT |-> bank_open != 4'h0;
    endproperty
    property p_pdn_idle;
        pwr_state inside {PS_PDN_PRE, PS_SREF} |-> bank_open == 4'h0;
    endproperty
    property p_frozen;
        s_asleep |-> $stable(term) && $stable(bank_open);
    endproperty
    property p_sref_wake;
        s_wake |-> ##[0:1] pwr_state == PS_ACTIVE;
    endproperty
    property p_term_same;
        term.dq == term.dqs && term.dqs == term.dm;
    endproperty
    property p_strobe_pair;
        !dqs_c_oe_n |-> !dqs_oe_n && dqs_c_o == !dqs_o;
    endproperty
    property p_data_edge;
        !dq_oe_n |-> !dqs_oe_n;
    endproperty
    // read strobe follows the ck level seen a couple of clk earlier
    property p_read_strobe;
        $changed(dqs_o) && !dqs_oe_n |-> dqs_o == $past(pins.ck_t, 2);
    endproperty

    a_buf_gate: assert property (p_buf_gate)
        else $error("buffer enable disagrees with power state");
    a_drv_off: assert property (p_drv_off)
        else $error("driver on while buffers off");
    a_pdn_act: assert property (p_pdn_act)
        else $error("active power-down with no open row");
    a_pdn_idle: assert property (p_pdn_idle)
        else $error("idle low-power state with open row");
    a_frozen: assert property (p_frozen)
        else $error("state moved while asleep");
    a_sref_wake: assert property (p_sref_wake)
        else $error("no wake from self-refresh");
    a_term_same: assert property (p_term_same)
        else $error("termination enables split");
    a_strobe_pair: assert property (p_strobe_pair)
        else $error("complement strobe wrong");
    a_data_edge: assert property (p_data_edge)
        else $error("data driven without strobe");
    a_read_strobe: assert property (p_read_strobe)
        else $error("read strobe not on ck level");
endmodule // dpc_pin_cmd_props

bind dpc_pin_cmd dpc_pin_cmd_props i_dpc_pin_cmd_props (
    .clk(clk), .nrst(nrst), .pins(pins), .dq_oe_n(dq_oe_n),
    .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n), .dqs_c_o(dqs_c_o),
    .dqs_c_oe_n(dqs_c_oe_n), .rdqs_oe_n(rdqs_oe_n), .term(term),
    .buf_en(buf_en), .pwr_state(pwr_state), .bank_open(bank_open)
);

`default_nettype wire

// ### sim/dpc_pin_cmd_tb.sv
/*
 * self-checking bench for dpc_pin_cmd with a controller model.
 * assumes the package, defines and props file compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.svh"

// ==========================================================================
// bench
module dpc_pin_cmd_tb
    import dpc_pkg::*;
;
    logic                 clk = 1'b0;
    logic                 nrst = 1'b0;
    dpc_pins_t            pins;
    logic [`DPC_DQ_W-1:0] dq_o;
    logic                 dq_oe_n, dqs_o, dqs_oe_n, dqs_c_o, dqs_c_oe_n;
    logic                 rdqs_o, rdqs_oe_n, buf_en;
    dpc_term_t            term;
    dpc_pwr_t             pwr_state;
    logic [3:0]           bank_open, ex;
    logic [7:0]           mem [4][16];
    logic [2:0]           mr_ba [4] = '{3'h1, 3'h0, 3'h1, 3'h1};
    logic [15:0]          mr_op [4] = '{16'h0004, 16'h0000, 16'h0040,
                                        16'h0000};
    logic                 mr_on [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    int                   n_mismatch = 0;
    int                   checks_done = 0;
    int                   b, cl;
    logic                 rq = 1'b0;

    always #12.5 clk = ~clk;

    dpc_ctrl_model i_dpc_ctrl_model (.clk(clk), .pins(pins));
    dpc_pin_cmd i_dpc_pin_cmd (
        .clk(clk), .nrst(nrst), .pins(pins), .dq_o(dq_o),
        .dq_oe_n(dq_oe_n), .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n),
        .dqs_c_o(dqs_c_o), .dqs_c_oe_n(dqs_c_oe_n), .rdqs_o(rdqs_o),
        .rdqs_oe_n(rdqs_oe_n), .term(term), .buf_en(buf_en),
        .pwr_state(pwr_state), .bank_open(bank_open)
    );

    function automatic logic [7:0] f_beat(logic [7:0] o, n, logic m);
        return m ? o : n;
    endfunction

    function automatic logic [3:0] f_pre(logic [3:0] o, int k, logic all);
        return all ? 4'h0 : o & ~(4'h1 << k);
    endfunction

    task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic cmd(logic [3:0] c, int k, logic [15:0] a, logic e);
        i_dpc_ctrl_model.cmd(c, 3'(k), a, e);
    endtask

    task automatic wr(int k, int c, logic [3:0] msk);
        logic [7:0] d;
        cmd(`DPC_CMD_WR, k, 16'(c), 1'b1);
        for (int n = 0; n < 4; n++) begin
            d = 8'($urandom);
            i_dpc_ctrl_model.beat(d, msk[n]);
            mem[k][(c+n)%16] = f_beat(mem[k][(c+n)%16], d,
                                      msk[n] & !rq);
        end
    endtask

    task automatic rd(int k, int c);
        cmd(`DPC_CMD_RD, k, 16'(c), 1'b1);
        for (int n = 0; n < 4; n++) begin
            if (n > 0) i_dpc_ctrl_model.tick();
            chk("rd_data", dq_o, mem[k][(c+n)%16]);
            chk("rd_strobe", dqs_o, 16'(n % 2));
            chk("rd_drive", dq_oe_n, 16'h0000);
            chk("rd_rdqs", rdqs_oe_n, 16'(!rq));
            chk("rd_rdqs_lvl", rdqs_o, 16'(n % 2));
            chk("rd_dqsn", dqs_c_oe_n, 16'(rq));
        end
        i_dpc_ctrl_model.tick();
        chk("rd_release", dq_oe_n, 16'h0001);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        void'($urandom(35));
        repeat (16) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        i_dpc_ctrl_model.w(8);
        chk("rst_pwr", pwr_state, PS_ACTIVE);
        chk("rst_open", bank_open, 16'h0000);
        chk("rst_term", term, 16'h0000);
        ex = 4'h0;
        for (int i = 0; i < 6; i++) begin
            b = $urandom % 8;
            cmd(`DPC_CMD_ACT, b, 16'($urandom), 1'b1);
            ex = ex | (4'h1 << (b % 4));
            chk("act", bank_open, ex);
        end
        cmd(`DPC_CMD_PRE, 0, 16'h0400, 1'b1);
        chk("pre_all", bank_open, f_pre(ex, 0, 1'b1));
        cmd(4'hb, 2, 16'h0000, 1'b1);
        chk("deselect", bank_open, 16'h0000);
        for (int i = 0; i < 4; i++) cmd(`DPC_CMD_ACT, i, 16'h0000, 1'b1);
        b = $urandom % 4;
        cmd(`DPC_CMD_PRE, b, 16'h0000, 1'b1);
        chk("pre_one", bank_open, f_pre(4'hf, b, 1'b0));
        cmd(`DPC_CMD_PRE, 0, 16'h0400, 1'b1);
        for (int i = 0; i < 4; i++) begin
            cmd(`DPC_CMD_MRS, mr_ba[i], mr_op[i], 1'b1);
            i_dpc_ctrl_model.set_odt(1'b1);
            cmd(`DPC_CMD_NOP, 0, 16'h0000, 1'b1);
            chk("odt_on", term, {13'h0, {3{mr_on[i]}}});
            i_dpc_ctrl_model.set_odt(1'b0);
            cmd(`DPC_CMD_NOP, 0, 16'h0000, 1'b1);
            chk("odt_off", term, 16'h0000);
        end
        // first burst wraps the column, second lands at random
        for (int j = 0; j < 2; j++) begin
            b = $urandom % 4;
            cl = j ? $urandom % 16 : 14;
            cmd(`DPC_CMD_ACT, b, 16'h0000, 1'b1);
            wr(b, cl, 4'h0);
            wr(b, cl, 4'h4);
            rd(b, cl);
            cmd(`DPC_CMD_PRE, 0, 16'h0400, 1'b1);
        end
        // mask pin as read strobe, complement strobe off, auto-precharge
        rq = 1'b1;
        cmd(`DPC_CMD_MRS, 1, 16'h0c04, 1'b1);
        i_dpc_ctrl_model.set_odt(1'b1);
        cmd(`DPC_CMD_ACT, 0, 16'h0000, 1'b1);
        chk("odt_rdqs", term, 16'h0007);
        i_dpc_ctrl_model.set_odt(1'b0);
        wr(0, 5, 4'ha);
        rd(0, 'h405);
        chk("ap_close", bank_open, 16'h0000);
        cmd(`DPC_CMD_MRS, 1, 16'h0000, 1'b1);
        rq = 1'b0;
        cmd(`DPC_CMD_ACT, 1, 16'h0000, 1'b1);
        cmd(`DPC_CMD_NOP, 0, 16'h0000, 1'b0);
        chk("pdn_act", pwr_state, PS_PDN_ACT);
        chk("pdn_buf", buf_en, 16'h0000);
        cmd(`DPC_CMD_ACT, 3, 16'h0000, 1'b0);
        chk("pdn_refuse", bank_open, 16'h0002);
        cmd(`DPC_CMD_NOP, 0, 16'h0000, 1'b1);
        chk("pdn_exit", pwr_state, PS_ACTIVE);
        cmd(`DPC_CMD_PRE, 1, 16'h0000, 1'b1);
        cmd(`DPC_CMD_NOP, 0, 16'h0000, 1'b0);
        chk("pdn_pre", pwr_state, PS_PDN_PRE);
        cmd(`DPC_CMD_NOP, 0, 16'h0000, 1'b1);
        cmd(`DPC_CMD_REF, 0, 16'h0000, 1'b0);
        chk("sref", pwr_state, PS_SREF);
        i_dpc_ctrl_model.wake();
        chk("sref_exit", pwr_state, PS_ACTIVE);
        cmd(`DPC_CMD_NOP, 0, 16'h0000, 1'b1);
        cmd(`DPC_CMD_ACT, 2, 16'h0000, 1'b1);
        chk("resume", bank_open, 16'h0004);
        end_of_test();
    end
endmodule // dpc_pin_cmd_tb

`default_nettype wire
